// [core/timer8_pkg.sv]
// Purpose: shared constants for the 8-bit timer waveform and compare-output block
// Assumes: APB, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package timer8_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL_A = 8'h30;
    localparam logic [7:0] OFS_CTRL_B = 8'h34;
    localparam logic [7:0] OFS_COUNT = 8'h38;
    localparam logic [7:0] OFS_CMP_A = 8'h3c;
    localparam logic [7:0] OFS_CMP_B = 8'h40;
    localparam logic [7:0] OFS_FLAGS = 8'h44;
    localparam logic [7:0] OFS_PIN_DIR = 8'h48;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CHAN_A_MODE_LSB = 6;
    localparam int CHAN_B_MODE_LSB = 4;
    localparam int WAVE_LOW_LSB = 0;
    localparam int WAVE_HIGH_POS = 3;
    localparam int RUN_POS = 0;
    localparam int OVF_FLAG_POS = 0;
    localparam int MATCH_A_FLAG_POS = 1;
    localparam int MATCH_B_FLAG_POS = 2;

    // bits 3 and 2 of control a are unimplemented
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
    localparam logic [7:0] CTRL_B_WMASK = 8'h09;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;

    // ----------------------------------------
    // counter constants and modes
    // ----------------------------------------
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam int TICK_DIV_DEFAULT = 1;

    typedef enum logic [2:0] {
        WAVE_NORMAL = 3'h0,
        WAVE_PC_FF = 3'h1,
        WAVE_CTC = 3'h2,
        WAVE_FAST_FF = 3'h3,
        WAVE_RSVD4 = 3'h4,
        WAVE_PC_CMPA = 3'h5,
        WAVE_RSVD6 = 3'h6,
        WAVE_FAST_CMPA = 3'h7
    } wave_mode_t;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } count_dir_t;

endpackage : timer8_pkg

// [core/compare_unit.sv]
// Purpose: one compare channel: match detect and compare-output register
// Assumes: tick is a one-cycle timer clock enable
// Notes:   toggle_in_pwm selects whether mode 01 toggles in pwm modes
module compare_unit
    import timer8_pkg::*;
#(
    parameter bit TOGGLE_IN_PWM = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic block_match,
    input wire logic [1:0] out_mode,
    input wire logic wave_high,
    input wire logic is_fast,
    input wire logic is_phase,
    input wire logic counting_up,
    input wire logic at_top,
    input wire logic [7:0] count,
    input wire logic [7:0] top,
    input wire logic [7:0] cmp_value,
    output logic match,
    output logic out_ff
);

    logic cmp_is_top;
    logic pwm;

    assign match = tick && !block_match && (count == cmp_value);
    assign cmp_is_top = (cmp_value == top);
    assign pwm = is_fast || is_phase;

    // ----------------------------------------
    // output register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 1'b0;
        end else if (tick) begin
            if (!pwm) begin
                if (match) begin
                    unique case (out_mode)
                        2'b01: out_ff <= ~out_ff;
                        2'b10: out_ff <= 1'b0;
                        2'b11: out_ff <= 1'b1;
                        default: out_ff <= out_ff;
                    endcase
                end
            end else if (out_mode == 2'b01) begin
                if (TOGGLE_IN_PWM && wave_high && match) begin
                    out_ff <= ~out_ff;
                end
            end else if (out_mode[1]) begin
                // match at top ignored, top action instead
                if (cmp_is_top) begin
                    if (at_top) begin
                        out_ff <= ~out_mode[0];
                    end
                end else if (is_fast) begin
                    if (at_top) begin
                        out_ff <= ~out_mode[0];
                    end else if (match) begin
                        out_ff <= out_mode[0];
                    end
                end else if (match) begin
                    out_ff <= counting_up ? out_mode[0] : ~out_mode[0];
                end
            end
        end
    end

endmodule : compare_unit

// [core/timer8_waveform_mode_control.sv]
// Purpose: 8-bit timer counter with waveform modes and two compare outputs
// Assumes: APB slave, zero wait states, 25 MHz pclk
// Notes:   timer clock is a one-cycle enable from a divider, never a clock
//
// What this block does
// - synchronous logic on pclk; timer clock is only a one-cycle enable
// - nonzero channel A output mode makes the compare output own the pin
// - nonzero channel B output mode makes the compare output own the pin
// - pin driver enabled only when the pin direction bit says output
// - non-pwm channel A: 00 off, 01 toggle, 10 clear, 11 set on match
// - pwm channel A mode 01: off if high wave bit 0, toggle if 1
// - fast pwm channel A: 10 clear on match set at top, 11 opposite
// - phase pwm channel A: 10 clear on up match set on down, 11 opposite
// - pwm: compare equal to top with high mode bit acts at top only
// - non-pwm channel B: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm channel B: 01 reserved, 10 clear/set at top, 11 opposite
// - phase pwm channel B: 01 reserved, 10 clear up set down, 11 opposite
// - control A bits 3 and 2 unimplemented, read zero
// - wave mode is two low bits of control A plus high bit of control B
// - modes 0 and 2: top 0xff or compare A, immediate update, flag at max
// - modes 1 and 5: top 0xff or compare A, update at top, flag at bottom
// - modes 3 and 7: update at top; flag at max for 3, at top for 7
// - max is 0xff and bottom is 0x00
// - fast pwm counts up to top then returns to bottom next tick
// - phase pwm reverses at top, top held for one tick
//
// Added by the designer: the APB register port.
module timer8_waveform_mode_control
    import timer8_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic chan_a_compare_out,
    output logic chan_b_compare_out,
    output logic chan_a_pin_override,
    output logic chan_b_pin_override,
    output logic chan_a_pin_oe,
    output logic chan_b_pin_oe
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic [7:0] cmp_sw_ff [2];
    logic [7:0] cmp_act_ff [2];
    logic [2:0] flags_ff;
    logic [1:0] pin_dir_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [1:0] override_ff;
    logic [1:0] oe_ff;
    logic [1:0] cmp_out_ff;
    logic block_ff;
    logic tick_ff;
    logic [15:0] div_ff;
    count_dir_t dir_ff;
    count_dir_t nxt_dir;
    wave_mode_t wave_mode;
    logic [7:0] top;
    logic [1:0] out_mode [2];
    logic [1:0] match;
    logic is_fast;
    logic is_phase;
    logic at_top;
    logic overflow_event;
    logic setup;
    logic wr_en;
    logic mapped;
    logic run;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready_ff;
    assign run = ctrl_b_ff[RUN_POS];

    // ----------------------------------------
    // timer clock enable
    // ----------------------------------------
    // divider pulse, not a derived clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (!run) begin
            div_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (div_ff >= 16'(TICK_DIV - 1)) begin
            div_ff <= 16'h0000;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    // three-bit wave mode
    assign wave_mode = wave_mode_t'({ctrl_b_ff[WAVE_HIGH_POS], ctrl_a_ff[WAVE_LOW_LSB +: 2]});
    assign is_fast = (wave_mode == WAVE_FAST_FF) || (wave_mode == WAVE_FAST_CMPA);
    assign is_phase = (wave_mode == WAVE_PC_FF) || (wave_mode == WAVE_PC_CMPA);
    assign out_mode[0] = ctrl_a_ff[CHAN_A_MODE_LSB +: 2];
    assign out_mode[1] = ctrl_a_ff[CHAN_B_MODE_LSB +: 2];

    always_comb begin
        unique case (wave_mode)
            WAVE_CTC, WAVE_PC_CMPA, WAVE_FAST_CMPA: top = cmp_act_ff[0];
            default: top = COUNT_MAX;
        endcase
    end

    assign at_top = tick_ff && (count_ff == top);

    // ----------------------------------------
    // counter sequence
    // ----------------------------------------
    // reserved modes 4 and 6 simply run as normal mode
    always_comb begin
        nxt_count = count_ff;
        nxt_dir = dir_ff;
        if (is_phase) begin
            // reverse at top and at bottom
            unique case (dir_ff)
                DIR_UP: begin
                    if (count_ff >= top) begin
                        nxt_dir = DIR_DOWN;
                        nxt_count = count_ff - 8'h01;
                    end else begin
                        nxt_count = count_ff + 8'h01;
                    end
                end
                DIR_DOWN: begin
                    if (count_ff == COUNT_BOTTOM) begin
                        nxt_dir = DIR_UP;
                        nxt_count = count_ff + 8'h01;
                    end else begin
                        nxt_count = count_ff - 8'h01;
                    end
                end
            endcase
        end else if (count_ff == top) begin
            nxt_dir = DIR_UP;
            nxt_count = COUNT_BOTTOM;
        end else begin
            nxt_dir = DIR_UP;
            nxt_count = count_ff + 8'h01;
        end
    end

    // a software write wins over the tick and masks the next match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= COUNT_RESET;
            dir_ff <= DIR_UP;
        end else if (wr_en && paddr == OFS_COUNT) begin
            count_ff <= pwdata[7:0];
        end else if (tick_ff) begin
            count_ff <= nxt_count;
            dir_ff <= nxt_dir;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_ff <= 1'b0;
        end else if (wr_en && paddr == OFS_COUNT) begin
            block_ff <= 1'b1;
        end else if (tick_ff) begin
            block_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // compare buffers
    // ----------------------------------------
    // immediate or at top
    for (genvar ch = 0; ch < 2; ch++) begin : g_buf
        localparam logic [7:0] OFS = (ch == 0) ? OFS_CMP_A : OFS_CMP_B;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cmp_sw_ff[ch] <= CMP_RESET;
            end else if (wr_en && paddr == OFS) begin
                cmp_sw_ff[ch] <= pwdata[7:0];
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cmp_act_ff[ch] <= CMP_RESET;
            end else if (!(is_fast || is_phase)) begin
                cmp_act_ff[ch] <= cmp_sw_ff[ch];
            end else if (at_top) begin
                cmp_act_ff[ch] <= cmp_sw_ff[ch];
            end
        end
    end

    // ----------------------------------------
    // compare units
    // ----------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
        // only channel A may toggle in pwm
        compare_unit #(
            .TOGGLE_IN_PWM(ch == 0)
        ) u_cmp (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick_ff),
            .block_match(block_ff),
            .out_mode(out_mode[ch]),
            .wave_high(ctrl_b_ff[WAVE_HIGH_POS]),
            .is_fast(is_fast),
            .is_phase(is_phase),
            .counting_up(dir_ff == DIR_UP),
            .at_top(at_top),
            .count(count_ff),
            .top(top),
            .cmp_value(cmp_act_ff[ch]),
            .match(match[ch]),
            .out_ff(cmp_out_ff[ch])
        );
    end

    // ----------------------------------------
    // pin control
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            override_ff <= 2'b00;
            oe_ff <= 2'b00;
        end else begin
            // any nonzero mode takes the pin
            override_ff[0] <= |out_mode[0];
            override_ff[1] <= |out_mode[1];
            // driver needs the direction bit too
            oe_ff[0] <= (|out_mode[0]) && pin_dir_ff[0];
            oe_ff[1] <= (|out_mode[1]) && pin_dir_ff[1];
        end
    end

    assign chan_a_compare_out = cmp_out_ff[0];
    assign chan_b_compare_out = cmp_out_ff[1];
    assign chan_a_pin_override = override_ff[0];
    assign chan_b_pin_override = override_ff[1];
    assign chan_a_pin_oe = oe_ff[0];
    assign chan_b_pin_oe = oe_ff[1];

    // ----------------------------------------
    // flags
    // ----------------------------------------
    // overflow point per mode
    always_comb begin
        unique case (wave_mode)
            WAVE_PC_FF, WAVE_PC_CMPA: overflow_event = tick_ff && count_ff == COUNT_BOTTOM;
            WAVE_FAST_CMPA: overflow_event = at_top;
            default: overflow_event = tick_ff && count_ff == COUNT_MAX;
        endcase
    end

    // write one clears; a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_en && paddr == OFS_FLAGS && pwdata[i]) begin
                    flags_ff[i] <= 1'b0;
                end
            end
            if (overflow_event) begin
                flags_ff[OVF_FLAG_POS] <= 1'b1;
            end
            if (match[0]) begin
                flags_ff[MATCH_A_FLAG_POS] <= 1'b1;
            end
            if (match[1]) begin
                flags_ff[MATCH_B_FLAG_POS] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // unimplemented bits never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_ff <= CTRL_A_RESET;
        end else if (wr_en && paddr == OFS_CTRL_A) begin
            ctrl_a_ff <= pwdata[7:0] & CTRL_A_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_b_ff <= CTRL_B_RESET;
        end else if (wr_en && paddr == OFS_CTRL_B) begin
            ctrl_b_ff <= pwdata[7:0] & CTRL_B_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_dir_ff <= 2'b00;
        end else if (wr_en && paddr == OFS_PIN_DIR) begin
            pin_dir_ff <= pwdata[1:0];
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    always_comb begin
        unique case (paddr)
            OFS_CTRL_A, OFS_CTRL_B, OFS_COUNT, OFS_CMP_A,
            OFS_CMP_B, OFS_FLAGS, OFS_PIN_DIR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // read data is captured in setup so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup) begin
            unique case (paddr)
                OFS_CTRL_A: prdata_ff <= {24'h00_0000, ctrl_a_ff};
                OFS_CTRL_B: prdata_ff <= {24'h00_0000, ctrl_b_ff};
                OFS_COUNT: prdata_ff <= {24'h00_0000, count_ff};
                OFS_CMP_A: prdata_ff <= {24'h00_0000, cmp_sw_ff[0]};
                OFS_CMP_B: prdata_ff <= {24'h00_0000, cmp_sw_ff[1]};
                OFS_FLAGS: prdata_ff <= {29'h0000_0000, flags_ff};
                OFS_PIN_DIR: prdata_ff <= {30'h0000_0000, pin_dir_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

endmodule : timer8_waveform_mode_control

// [tb/timer8_waveform_mode_control_asserts.sv]
// Purpose: port-level checks for the timer waveform block
// Assumes: apb slave answering in the first access cycle
// Notes:   sees only the top-level ports
module timer8_waveform_mode_control_chk
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan_a_compare_out,
    input wire logic chan_b_compare_out,
    input wire logic chan_a_pin_override,
    input wire logic chan_b_pin_override,
    input wire logic chan_a_pin_oe,
    input wire logic chan_b_pin_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr_a;
    logic wr_dir;
    logic mapped;
    assign acc = psel && penable && pready;
    assign wr_a = acc && pwrite && paddr == OFS_CTRL_A;
    assign wr_dir = acc && pwrite && paddr == OFS_PIN_DIR;
    assign mapped = paddr inside {OFS_CTRL_A, OFS_CTRL_B, OFS_COUNT, OFS_CMP_A, OFS_CMP_B, OFS_FLAGS, OFS_PIN_DIR};
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_oe_a_gated: assert property (chan_a_pin_oe |-> chan_a_pin_override)
        else $error("pin a driver on without override");
    a_oe_b_gated: assert property (chan_b_pin_oe |-> chan_b_pin_override)
        else $error("pin b driver on without override");
    a_ovr_a_mode: assert property (wr_a |-> ##2 chan_a_pin_override == (|$past(pwdata[7:6], 2)))
        else $error("pin a override does not follow mode");
    a_ovr_b_mode: assert property (wr_a |-> ##2 chan_b_pin_override == (|$past(pwdata[5:4], 2)))
        else $error("pin b override does not follow mode");
    a_ovr_a_held: assert property ($changed(chan_a_pin_override) |-> $past(wr_a, 2))
        else $error("pin a override moved without a write");
    a_ctrl_a_zero: assert property (acc && !pwrite && paddr == OFS_CTRL_A |-> prdata[31:8] == 24'h0 && prdata[3:2] == 2'b00)
        else $error("unimplemented control bits read nonzero");
    a_oe_dir: assert property (wr_dir |-> ##2 chan_a_pin_oe == (chan_a_pin_override && $past(pwdata[0], 2)))
        else $error("pin a driver ignores direction");
    a_ready_next: assert property (psel && !penable |=> pready && penable)
        else $error("no answer in the first access cycle");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("error response wrong for address");
endmodule : timer8_waveform_mode_control_chk

// [tb/port_pin_model.sv]
// Purpose: port pin logic beside one compare output
// Assumes: pin pulled to PULL when nobody drives it
// Notes:   resolves pin level from override, driver enable and port data
module port_pin_model #(
    parameter logic PULL = 1'b1
) (
    input wire logic override,
    input wire logic oe,
    input wire logic compare_out,
    input wire logic port_data,
    input wire logic port_dir,
    output logic pin
);
    always_comb begin
        if (oe) begin
            pin = compare_out;
        end else if (!override && port_dir) begin
            pin = port_data;
        end else begin
            // released pin: only the pull holds it
            pin = PULL;
        end
    end
endmodule : port_pin_model

// [tb/timer8_waveform_mode_control_bench.sv]
// Purpose: self-checking bench for the timer waveform block
// Assumes: tick every pclk (TICK_DIV 1)
// Notes:   waveforms judged by measured high and low times
module timer8_waveform_mode_control_bench
    import timer8_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, oa, ob, ova, ovb, oea, oeb, pin_a, pin_b, e;
    logic [1:0] port_dir = 2'b00, port_data = 2'b11;
    int failures = 0, checks_done = 0, cycles = 0;
    always #20 pclk = ~pclk;
    timer8_waveform_mode_control #(.TICK_DIV(1)) i_timer8_waveform_mode_control (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_a_compare_out(oa), .chan_b_compare_out(ob),
        .chan_a_pin_override(ova), .chan_b_pin_override(ovb), .chan_a_pin_oe(oea), .chan_b_pin_oe(oeb));
    port_pin_model i_port_pin_model_a (.override(ova), .oe(oea), .compare_out(oa), .port_data(port_data[0]),
        .port_dir(port_dir[0]), .pin(pin_a));
    port_pin_model i_port_pin_model_b (.override(ovb), .oe(oeb), .compare_out(ob), .port_data(port_data[1]),
        .port_dir(port_dir[1]), .pin(pin_b));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task results;
        $display("failures=%0d checks_done=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // setup at one edge, access until pready seen high, release after it
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        if (n == 16) failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    function logic lvl(input logic ch);
        return ch ? ob : oa;
    endfunction : lvl
    // lo of zero asks for a steady level hi[0] instead of a waveform
    task run_case(input logic [7:0] ca, input logic wh, input logic [7:0] ma, input logic [7:0] mb,
                  input logic ch, input int hi, input int lo);
        int n;
        int h;
        int l;
        do_reset();
        apb(1'b1, OFS_CMP_A, {24'h0, ma});
        apb(1'b1, OFS_CMP_B, {24'h0, mb});
        apb(1'b1, OFS_CTRL_A, {24'h0, ca});
        apb(1'b1, OFS_CTRL_B, {28'h0, wh, 3'b001});
        n = 0;
        h = 0;
        l = 0;
        if (lo == 0) begin
            repeat (320) @(negedge pclk);
            repeat (64) begin
                @(negedge pclk);
                if (lvl(ch) !== hi[0]) n++;
            end
            chk(n, 0);
        end else begin
            while (lvl(ch) !== 1'b0 && n < 2000) begin @(negedge pclk); n++; end
            while (lvl(ch) !== 1'b1 && n < 2000) begin @(negedge pclk); n++; end
            while (lvl(ch) === 1'b1 && n < 2000) begin @(negedge pclk); n++; h++; end
            while (lvl(ch) === 1'b0 && n < 2000) begin @(negedge pclk); n++; l++; end
            chk(h, hi);
            chk(l, lo);
        end
    endtask : run_case
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            results();
        end
    end
    initial begin
        do_reset();
        apb(1'b0, OFS_CTRL_A, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, OFS_CTRL_A, 32'hffff_ffff);
        apb(1'b0, OFS_CTRL_A, 32'h0);
        chk(q, 32'hf3);
        apb(1'b0, 8'h80, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, OFS_CTRL_A, 32'h80);
        repeat (3) @(negedge pclk);
        chk({ova, oea, pin_a}, 3'b101);
        apb(1'b1, OFS_PIN_DIR, 32'h3);
        port_dir <= 2'b11;
        repeat (3) @(negedge pclk);
        chk({ova, oea, pin_a, ovb, oeb, pin_b}, 6'b110001);
        apb(1'b1, OFS_CTRL_A, 32'h10);
        repeat (3) @(negedge pclk);
        chk({ova, oea, ovb, oeb, pin_b}, 5'b00110);
        // count register, overflow at max and match flags in normal mode
        apb(1'b1, OFS_CMP_A, 32'h80);
        apb(1'b1, OFS_COUNT, 32'hf0);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk(q, 32'hf0);
        apb(1'b1, OFS_CTRL_B, 32'h1);
        repeat (30) @(posedge pclk);
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk(q, 32'h5);
        apb(1'b1, OFS_FLAGS, 32'h5);
        apb(1'b0, OFS_FLAGS, 32'h0);
        chk(q, 32'h0);
        run_case(8'h40, 1'b0, 8'h10, 8'h00, 1'b0, 256, 256);
        run_case(8'hc0, 1'b0, 8'h10, 8'h00, 1'b0, 1, 0);
        run_case(8'h12, 1'b0, 8'h1f, 8'h05, 1'b1, 32, 32);
        run_case(8'h83, 1'b0, 8'h40, 8'h00, 1'b0, 65, 191);
        run_case(8'hc3, 1'b0, 8'h40, 8'h00, 1'b0, 191, 65);
        run_case(8'h43, 1'b0, 8'h10, 8'h00, 1'b0, 0, 0);
        run_case(8'h43, 1'b1, 8'h10, 8'h00, 1'b0, 17, 17);
        run_case(8'h23, 1'b1, 8'h20, 8'h08, 1'b1, 9, 24);
        run_case(8'h13, 1'b0, 8'h40, 8'h10, 1'b1, 0, 0);
        run_case(8'h83, 1'b1, 8'h20, 8'h00, 1'b0, 1, 0);
        run_case(8'h81, 1'b0, 8'h40, 8'h00, 1'b0, 128, 382);
        run_case(8'h31, 1'b1, 8'h30, 8'h10, 1'b1, 64, 32);
        results();
    end
endmodule : timer8_waveform_mode_control_bench

bind timer8_waveform_mode_control timer8_waveform_mode_control_chk i_timer8_waveform_mode_control_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_a_compare_out(chan_a_compare_out), .chan_b_compare_out(chan_b_compare_out),
    .chan_a_pin_override(chan_a_pin_override), .chan_b_pin_override(chan_b_pin_override),
    .chan_a_pin_oe(chan_a_pin_oe), .chan_b_pin_oe(chan_b_pin_oe));
